// ===== design/sadc_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SADC_REGS_SVH
`define SADC_REGS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define SADC_CTRL0_OFS 8'h00
`define SADC_CTRL1_OFS 8'h04
`define SADC_RESH_OFS 8'h08
`define SADC_RESL_OFS 8'h0C
`define SADC_STAT_OFS 8'h10
`define SADC_MASK_OFS 8'h14

// ****************************************
// Field positions
// ****************************************
`define SADC_C0_ENABLE_BIT 0
`define SADC_C0_GO_BIT 1
`define SADC_C0_CHS_LSB 2
`define SADC_C0_JUST_BIT 8
`define SADC_C1_REF_LSB 0
`define SADC_C1_CLK_LSB 4
`define SADC_STAT_DONE_BIT 0

// ****************************************
// Reset values and timing counts
// ****************************************
`define SADC_CTRL0_RST 32'h0000_0000
`define SADC_CTRL1_RST 32'h0000_0000
`define SADC_RC_DIV 16
`define SADC_CONV_PERIODS 11
`define SADC_ABORT_PERIODS 2

`endif

// ===== design/sadc_pkg.sv
// Types shared by the converter control block
package sadc_pkg;
    typedef enum logic [1:0] {
        SadcIdle,
        SadcConvert,
        SadcAbortWait
    } sadc_state_e;

    typedef struct packed {
        logic [5:0] channel;
        logic sample;
        logic [1:0] reference;
    } sadc_analog_s;
endpackage : sadc_pkg

// ===== design/sadc_control.sv
// Successive-approximation converter control with AXI4-Lite registers
// Function
// - Multiplexer routes one input into sample-hold
// - Ten-bit SAR result in high/low pair
// - Two-bit reference select field chooses converter reference
// - Completion interrupt, usable for sleep wakeup
// - Channel field picks sample-hold input
// - Clock field: sysclk /8,/16,/32,/64 or RC
// - RC clock is internal oscillator /16
// - Full conversion takes eleven clock periods
// - Non-RC conversion clock follows system clock
// - Completion clears go, sets flag, loads result
// - Flag set every completion, software clears
// - Abort keeps result, two-period wait follows
// - Justify bit selects left or right alignment
`timescale 1ns/1ps
`include "sadc_regs.svh"

module sadc_control #(
    parameter int CHAN_W = 6
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic rcOscClk,
    input wire logic compHigh,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output sadc_pkg::sadc_analog_s analogCtrl_q,
    output logic [9:0] dacCode_q,
    output logic irq_q
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [1:0] rcSync_q;
    logic [1:0] compSync_q;
    logic rcLast_q;

    always_ff @(posedge core_clk) begin
        rcSync_q <= {rcSync_q[0], rcOscClk};
        compSync_q <= {compSync_q[0], compHigh};
        rcLast_q <= rcSync_q[1];
    end

    // ****************************************
    // Control registers
    // ****************************************
    logic enable_q;
    logic go_q;
    logic justify_q;
    logic [CHAN_W-1:0] channel_q;
    logic [1:0] refSel_q;
    logic [2:0] clkSel_q;
    logic [7:0] resHigh_q;
    logic [7:0] resLow_q;
    logic done_q;
    logic mask_q;

    // ****************************************
    // AXI4-Lite handshake
    // ****************************************
    logic awHeld_q;
    logic wHeld_q;
    logic [7:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    wire logic wrFire = awHeld_q && wHeld_q && !s_axi_bvalid;
    wire logic rdFire = s_axi_arvalid && s_axi_arready;

    // Write decode
    wire logic wrCtrl0 = wrFire && awAddr_q == `SADC_CTRL0_OFS;
    wire logic wrCtrl1 = wrFire && awAddr_q == `SADC_CTRL1_OFS;
    wire logic wrStat = wrFire && awAddr_q == `SADC_STAT_OFS;
    wire logic wrMask = wrFire && awAddr_q == `SADC_MASK_OFS;
    wire logic wrHit = wrCtrl0 || wrCtrl1 || wrStat || wrMask ||
        awAddr_q == `SADC_RESH_OFS || awAddr_q == `SADC_RESL_OFS;
    wire logic [31:0] wd = wData_q;
    wire logic lane0 = wStrb_q[0];
    wire logic lane1 = wStrb_q[1];

    // Address and data captured independently, response follows both
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            s_axi_awready <= !awHeld_q && !s_axi_awready;
            s_axi_wready <= !wHeld_q && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (wrFire) begin
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrHit ? 2'b00 : 2'b10;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // Conversion sequencer
    // ****************************************
    sadc_pkg::sadc_state_e state_q;
    logic [5:0] preCnt_q;
    logic [3:0] rcCnt_q;
    logic [3:0] period_q;
    logic [9:0] sar_q;

    // Prescale selects: /8 /16 /32 /64 from system clock, RC /16
    wire logic rcEdge = rcSync_q[1] && !rcLast_q;
    wire logic rcMode = clkSel_q[1:0] == 2'b11;
    wire logic [5:0] preMax = (clkSel_q == 3'b001) ? 6'd7 :
        (clkSel_q == 3'b101) ? 6'd15 :
        (clkSel_q == 3'b010) ? 6'd31 : 6'd63;
    wire logic sysTick = !rcMode && preCnt_q == preMax;
    wire logic rcTick = rcMode && rcEdge &&
        rcCnt_q == 4'(`SADC_RC_DIV - 1);
    wire logic tadTick = sysTick || rcTick;

    // Go may be set by software only when enabled and idle
    wire logic startReq = wrCtrl0 && lane0 && wd[`SADC_C0_GO_BIT] &&
        wd[`SADC_C0_ENABLE_BIT] && enable_q &&
        state_q == sadc_pkg::SadcIdle;
    wire logic abortReq = wrCtrl0 && lane0 && !wd[`SADC_C0_GO_BIT] &&
        state_q == sadc_pkg::SadcConvert;
    wire logic stopConv = state_q == sadc_pkg::SadcConvert &&
        (abortReq || !enable_q);
    wire logic holdDiv = state_q == sadc_pkg::SadcIdle || stopConv;
    wire logic lastPeriod = tadTick &&
        period_q == 4'(`SADC_CONV_PERIODS - 1);
    wire logic convDone = state_q == sadc_pkg::SadcConvert &&
        lastPeriod && !abortReq && enable_q;
    wire logic [9:0] bitMask = 10'(11'h400 >> period_q);
    wire logic [9:0] sarNext = compSync_q[1] ? sar_q :
        (sar_q & ~bitMask);

    // Dividers restart at start and abort, so every period is whole
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            preCnt_q <= 6'd0;
            rcCnt_q <= 4'd0;
        end else begin
            preCnt_q <= (sysTick || holdDiv) ? 6'd0 : preCnt_q + 6'd1;
            if (holdDiv) begin
                rcCnt_q <= 4'd0;
            end else if (rcEdge) begin
                rcCnt_q <= rcCnt_q + 4'd1;
            end
        end
    end

    // Sequencer: one bit decided per period after the first, last period loads result
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q <= sadc_pkg::SadcIdle;
            period_q <= 4'd0;
            sar_q <= 10'h000;
        end else begin
            case (state_q)
                sadc_pkg::SadcIdle: begin
                    period_q <= 4'd0;
                    sar_q <= 10'h200;
                    if (startReq) begin
                        state_q <= sadc_pkg::SadcConvert;
                    end
                end
                sadc_pkg::SadcConvert: begin
                    if (stopConv) begin
                        period_q <= 4'd0;
                        state_q <= sadc_pkg::SadcAbortWait;
                    end else if (lastPeriod) begin
                        state_q <= sadc_pkg::SadcIdle;
                    end else if (tadTick) begin
                        period_q <= period_q + 4'd1;
                        sar_q <= sarNext | (bitMask >> 1);
                    end
                end
                sadc_pkg::SadcAbortWait: begin
                    if (tadTick) begin
                        period_q <= period_q + 4'd1;
                        if (period_q == 4'(`SADC_ABORT_PERIODS - 1)) begin
                            state_q <= sadc_pkg::SadcIdle;
                        end
                    end
                end
                default: state_q <= sadc_pkg::SadcIdle;
            endcase
        end
    end

    // ****************************************
    // Register updates
    // ****************************************
    wire logic [9:0] finalCode = sarNext;
    wire logic [7:0] nextHigh = justify_q ? {6'h00, finalCode[9:8]} :
        finalCode[9:2];
    wire logic [7:0] nextLow = justify_q ? finalCode[7:0] :
        {finalCode[1:0], 6'h00};

    // Control, result and interrupt state
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            enable_q <= 1'b0;
            go_q <= 1'b0;
            justify_q <= 1'b0;
            channel_q <= '0;
            refSel_q <= 2'b00;
            clkSel_q <= 3'b000;
            resHigh_q <= 8'h00;
            resLow_q <= 8'h00;
            done_q <= 1'b0;
            mask_q <= 1'b0;
        end else begin
            if (wrCtrl0 && lane0) begin
                enable_q <= wd[`SADC_C0_ENABLE_BIT];
                channel_q <= wd[`SADC_C0_CHS_LSB +: CHAN_W];
            end
            if (wrCtrl0 && lane1) begin
                justify_q <= wd[`SADC_C0_JUST_BIT];
            end
            if (wrCtrl1 && lane0) begin
                refSel_q <= wd[`SADC_C1_REF_LSB +: 2];
                clkSel_q <= wd[`SADC_C1_CLK_LSB +: 3];
            end
            if (wrMask && lane0) begin
                mask_q <= wd[`SADC_STAT_DONE_BIT];
            end
            if (startReq) begin
                go_q <= 1'b1;
            end else if (abortReq || convDone || !enable_q) begin
                go_q <= 1'b0;
            end
            if (convDone) begin
                resHigh_q <= nextHigh;
                resLow_q <= nextLow;
            end
            if (convDone) begin
                done_q <= 1'b1;
            end else if (wrStat && lane0 && wd[`SADC_STAT_DONE_BIT]) begin
                done_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // Analog-side outputs and interrupt
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            analogCtrl_q <= '0;
            dacCode_q <= 10'h000;
            irq_q <= 1'b0;
        end else begin
            analogCtrl_q.channel <= 6'(channel_q);
            analogCtrl_q.sample <= enable_q &&
                state_q == sadc_pkg::SadcIdle;
            analogCtrl_q.reference <= refSel_q;
            dacCode_q <= sar_q;
            irq_q <= (done_q || convDone) && mask_q;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    wire logic [31:0] ctrl0Val = {23'h0, justify_q, 6'(channel_q),
        go_q, enable_q};
    wire logic [31:0] rdVal =
        (s_axi_araddr[7:0] == `SADC_CTRL0_OFS) ? ctrl0Val :
        (s_axi_araddr[7:0] == `SADC_CTRL1_OFS) ?
            {25'h0, clkSel_q, 2'b00, refSel_q} :
        (s_axi_araddr[7:0] == `SADC_RESH_OFS) ? {24'h0, resHigh_q} :
        (s_axi_araddr[7:0] == `SADC_RESL_OFS) ? {24'h0, resLow_q} :
        (s_axi_araddr[7:0] == `SADC_STAT_OFS) ? {31'h0, done_q} :
        (s_axi_araddr[7:0] == `SADC_MASK_OFS) ? {31'h0, mask_q} :
        32'h0000_0000;
    wire logic rdHit = s_axi_araddr[7:0] <= `SADC_MASK_OFS &&
        s_axi_araddr[1:0] == 2'b00;

    // Read answered one cycle after address accepted
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready &&
                s_axi_arvalid;
            if (rdFire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdVal;
                s_axi_rresp <= rdHit ? 2'b00 : 2'b10;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule : sadc_control

// ===== tb/sadc_control_properties.sv
// Port-level assertions for the converter control block
`timescale 1ns/1ps
`include "sadc_regs.svh"
module sadc_control_properties (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire sadc_pkg::sadc_analog_s analogCtrl_q,
    input wire logic [9:0] dacCode_q,
    input wire logic irq_q
);
    // ****************************************
    // Checks
    // ****************************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Write or read request accepted at one edge
    sequence sWrTaken(logic [7:0] ofs);
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            && s_axi_awaddr[7:0] == ofs;
    endsequence
    sequence sRdTaken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_reset_quiet: assert property (
        $rose(rst_n) |-> !irq_q && analogCtrl_q == '0)
        else $error("outputs not clear after reset");
    a_read_answer: assert property (sRdTaken |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_error: assert property (
        sRdTaken ##0 s_axi_araddr > 32'h0000_0014
        |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    a_start_acq: assert property (
        sWrTaken(`SADC_CTRL0_OFS) ##0
        (s_axi_wdata[1:0] == 2'b11 && analogCtrl_q.sample)
        |-> ##[1:4] !analogCtrl_q.sample)
        else $error("go did not end acquisition");
    a_off_idle: assert property (
        sWrTaken(`SADC_CTRL0_OFS) ##0 !s_axi_wdata[0]
        |-> ##[1:3] !analogCtrl_q.sample)
        else $error("sampling while disabled");
    a_chan_follow: assert property (
        sWrTaken(`SADC_CTRL0_OFS)
        |-> ##3 analogCtrl_q.channel == $past(s_axi_wdata[7:2], 3))
        else $error("channel not routed");
    a_irq_clear: assert property (
        sWrTaken(`SADC_STAT_OFS) ##0 s_axi_wdata[0] |-> ##[1:3] !irq_q)
        else $error("interrupt not cleared");
    a_bit_period: assert property (
        $changed(dacCode_q) && !analogCtrl_q.sample
        |=> $stable(dacCode_q) [*7])
        else $error("trial code faster than period");
endmodule : sadc_control_properties

bind sadc_control sadc_control_properties u_props (.*);

// ===== tb/sadc_analog_model.sv
// Comparator and sample-hold model for the converter control bench
`timescale 1ns/1ps
module sadc_analog_model (
    input wire logic core_clk,
    input wire logic slowMode,
    input wire sadc_pkg::sadc_analog_s analogCtrl_q,
    input wire logic [9:0] dacCode_q,
    output logic compHigh
);
    logic [9:0] level;
    logic late_q = 1'b0;
    logic flip_q = 1'b0;
    // Level of the selected input held by the sample stage
    assign level = {analogCtrl_q.channel, 4'h5};
    // Slow answer lags a cycle; noise while sampling
    always @(posedge core_clk) begin
        late_q <= level >= dacCode_q;
        flip_q <= !flip_q;
    end
    assign compHigh = analogCtrl_q.sample ? flip_q
        : slowMode ? late_q : level >= dacCode_q;
endmodule : sadc_analog_model

// ===== tb/tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "sadc_regs.svh"
module tb;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic rcOscClk = 1'b0;
    logic slowMode = 1'b0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irq_q, compHigh;
    logic [1:0] s_axi_bresp, s_axi_rresp, wrResp;
    logic [31:0] s_axi_rdata, resH, resL;
    logic [9:0] dacCode_q;
    sadc_pkg::sadc_analog_s analogCtrl_q;
    int failCount = 0, checksDone = 0, cycles = 0;
    logic [2:0] selTab [5] = '{3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
    int divTab [5] = '{8, 16, 32, 64, 0};

    sadc_control dut (.*);
    sadc_analog_model model (.*);

    // ****************************************
    // Clocks, limit and shared tasks
    // ****************************************
    always #2 core_clk = ~core_clk;
    always #9 rcOscClk = ~rcOscClk;
    // Cycle count with a ceiling against hangs
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failCount++;
            $display("wrong value at %0t: run too long", $time);
            finalReport();
        end
    end
    task automatic finalReport();
        $display("checks %0d mismatches %0d", checksDone, failCount);
        if (failCount == 0 && checksDone > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finalReport
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            failCount++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask : check
    task automatic axWrite(input logic [7:0] ofs, input logic [31:0] d);
        @(posedge core_clk);
        s_axi_awaddr <= {24'h00_0000, ofs};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        wrResp = s_axi_bresp;
    endtask : axWrite
    task automatic axRead(input logic [7:0] ofs, output logic [31:0] d,
            output logic [1:0] resp);
        @(posedge core_clk);
        s_axi_araddr <= {24'h00_0000, ofs};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        resp = s_axi_rresp;
    endtask : axRead
    task automatic rdCheck(input logic [7:0] ofs, input logic [31:0] exp,
            input logic [1:0] resp);
        logic [31:0] d;
        logic [1:0] r;
        axRead(ofs, d, r);
        check(d, exp);
        check(32'(r), 32'(resp));
    endtask : rdCheck
    // Go refused without prior enable; unmapped read
    task automatic startGuard();
        axWrite(`SADC_CTRL1_OFS, 32'h0000_0010);
        axWrite(`SADC_CTRL0_OFS, 32'h0000_0003);
        repeat (120) @(posedge core_clk);
        rdCheck(`SADC_STAT_OFS, 0, 2'b00);
        rdCheck(`SADC_CTRL0_OFS, 1, 2'b00);
        check(32'(analogCtrl_q.sample), 1);
        axWrite(`SADC_CTRL0_OFS, 0);
        repeat (3) @(posedge core_clk);
        check(32'(analogCtrl_q.sample), 0);
        rdCheck(8'h18, 0, 2'b10);
        axWrite(8'h18, 1);
        check(32'(wrResp), 2);
        $display("start guard test done");
    endtask : startGuard
    // One conversion with chosen clock, channel, format and mask
    task automatic convert(input logic [2:0] sel, input int div,
            input logic [5:0] ch, input logic msk);
        logic [9:0] res;
        logic [31:0] c0;
        logic [31:0] rd;
        logic [1:0] rsp;
        int t0;
        res = {ch, 4'h5};
        c0 = {23'h00_0000, ch[0], ch, 2'b01};
        resH = ch[0] ? 32'(res[9:8]) : 32'(res[9:2]);
        resL = ch[0] ? 32'(res[7:0]) : 32'({res[1:0], 6'h00});
        axWrite(`SADC_MASK_OFS, 32'(msk));
        axWrite(`SADC_CTRL1_OFS, {25'h000_0000, sel, 2'b00, ch[1:0]});
        axWrite(`SADC_CTRL0_OFS, c0);
        repeat (20) @(posedge core_clk);
        check(32'(analogCtrl_q), 32'({ch, 1'b1, ch[1:0]}));
        t0 = cycles;
        axWrite(`SADC_CTRL0_OFS, c0 | 32'h0000_0002);
        do axRead(`SADC_CTRL0_OFS, rd, rsp);
        while (rd[1] !== 1'b0);
        check(rd, c0);
        check(32'(rsp), 0);
        if (div > 0)
            check(32'(cycles - t0 >= 11 * div
                && cycles - t0 <= 12 * div + 20), 1);
        rdCheck(`SADC_STAT_OFS, 1, 2'b00);
        rdCheck(`SADC_RESH_OFS, resH, 2'b00);
        rdCheck(`SADC_RESL_OFS, resL, 2'b00);
        check(32'(irq_q), 32'(msk));
        axWrite(`SADC_STAT_OFS, 1);
        rdCheck(`SADC_STAT_OFS, 0, 2'b00);
        check(32'(irq_q), 0);
        $display("conversion on clock %b done", sel);
    endtask : convert
    // Abort mid-conversion keeps the old result
    task automatic abortRun();
        axWrite(`SADC_CTRL1_OFS, 32'h0000_0060);
        axWrite(`SADC_CTRL0_OFS, 32'h0000_0107);
        repeat (230) @(posedge core_clk);
        axWrite(`SADC_CTRL0_OFS, 32'h0000_0105);
        repeat (100) @(posedge core_clk);
        check(32'(analogCtrl_q.sample), 0);
        repeat (110) @(posedge core_clk);
        check(32'(analogCtrl_q.sample), 1);
        rdCheck(`SADC_STAT_OFS, 0, 2'b00);
        rdCheck(`SADC_RESH_OFS, resH, 2'b00);
        rdCheck(`SADC_RESL_OFS, resL, 2'b00);
        $display("abort test done");
    endtask : abortRun
    // Reset in mid-conversion clears controls
    task automatic resetRun();
        axWrite(`SADC_MASK_OFS, 1);
        axWrite(`SADC_CTRL0_OFS, 32'h0000_0103);
        repeat (30) @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        check(32'(analogCtrl_q), 0);
        for (int i = 0; i < 24; i += 4)
            if (i != 8 && i != 12) rdCheck(8'(i), 0, 2'b00);
        $display("reset test done");
    endtask : resetRun

    // Main sequence
    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        startGuard();
        for (int i = 0; i < 5; i++) begin
            slowMode <= i[0];
            convert(selTab[i], divTab[i], 6'(i * 13), i[1]);
        end
        abortRun();
        resetRun();
        finalReport();
    end
endmodule : tb
